// ===== amp_regs_pkg.sv
/*
 * Constants for the amplifier status, pin mask and AC diagnostic register bank.
 * Assumes 8-bit registers behind a two-wire control bus target.
 */
package amp_regs_pkg;
   // Register offsets
   localparam logic [7:0] THERMAL_SHUTDOWN_FLAGS_OFS = 8'h12;
   localparam logic [7:0] WARNING_FLAGS_OFS = 8'h13;
   localparam logic [7:0] FAULT_PIN_MASK_OFS = 8'h14;
   localparam logic [7:0] AC_DIAG_GAIN_ENABLE_OFS = 8'h15;
   localparam logic [7:0] AC_DIAG_SETUP_OFS = 8'h16;
   // Values after reset
   localparam logic [7:0] THERMAL_SHUTDOWN_FLAGS_RST = 8'h00;
   localparam logic [7:0] WARNING_FLAGS_RST = 8'h20;
   localparam logic [7:0] FAULT_PIN_MASK_RST = 8'h00;
   localparam logic [7:0] AC_DIAG_GAIN_ENABLE_RST = 8'h00;
   localparam logic [7:0] AC_DIAG_SETUP_RST = 8'h00;
   // Field positions
   localparam int OVERTEMP_SHUTDOWN_FLAG_GLOBAL_BIT = 4;
   localparam int POR_BIT = 5;
   localparam int OTW_GLOBAL_BIT = 4;
   localparam int OVERCURRENT_MASK_BIT = 7;
   localparam int THERMAL_SHUTDOWN_MASK_BIT = 6;
   localparam int UNDERVOLTAGE_MASK_BIT = 5;
   localparam int OVERVOLTAGE_MASK_BIT = 4;
   localparam int DC_OFFSET_MASK_BIT = 3;
   localparam int CLIP_MASK_BIT = 1;
   localparam int THERMAL_WARNING_MASK_BIT = 0;
   localparam int LOOPBACK_BIT = 7;
   localparam int MEASURE_LENGTH_BIT = 4;
   localparam int TEST_CURRENT_LSB = 2;
   localparam int GAIN_PAIR12_BIT = 7;
   localparam int GAIN_PAIR34_BIT = 5;
   // Measurement lengths in cycles
   localparam logic [6:0] MEASURE_SHORT_CYCLES = 7'h20;
   localparam logic [6:0] MEASURE_LONG_CYCLES = 7'h40;
   // Control bus target states
   typedef enum logic [3:0] {
      BUS_IDLE = 4'b0000,
      BUS_ADDR = 4'b0001,
      BUS_ACK_ADDR = 4'b0010,
      BUS_REG = 4'b0011,
      BUS_ACK_REG = 4'b0100,
      BUS_WDATA = 4'b0101,
      BUS_ACK_WDATA = 4'b0110,
      BUS_RDATA = 4'b0111,
      BUS_ACK_RDATA = 4'b1000
   } bus_state_e;
endpackage

// ===== ctrl_bus_target.sv
/*
 * Two-wire control bus target: address match, register pointer, byte writes
 * and reads with pointer auto-increment. Assumes clock and data inputs are
 * synchronous to core_clk_i and much slower than it.
 */
`timescale 1ns/1ps
module ctrl_bus_target #(
   parameter logic [6:0] DEV_ADDR = 7'h6a // Arbitrary default
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   // Register side
   output logic wr_stb_o,
   output logic [7:0] ptr_o,
   output logic [7:0] wr_data_o,
   input wire logic [7:0] rd_data_i
);
   amp_regs_pkg::bus_state_e state_r, state_nxt;
   logic scl_d_r, sda_d_r;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, wd_r, wd_nxt;
   logic oe_r, oe_nxt, rw_r, rw_nxt, wr_r, wr_nxt;
   logic rise, fall, start, stop;

   // Edge and condition detection on the previous sample
   assign rise = scl_i && !scl_d_r;
   assign fall = !scl_i && scl_d_r;
   assign start = scl_i && scl_d_r && sda_d_r && !sda_i;
   assign stop = scl_i && scl_d_r && !sda_d_r && sda_i;

   // Byte engine; data out changes only while the clock is low
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      ptr_nxt = ptr_r;
      wd_nxt = wd_r;
      oe_nxt = oe_r;
      rw_nxt = rw_r;
      wr_nxt = 1'b0;
      if (start) begin
         state_nxt = amp_regs_pkg::BUS_ADDR;
         cnt_nxt = 4'h0;
         oe_nxt = 1'b0;
      end else if (stop) begin
         state_nxt = amp_regs_pkg::BUS_IDLE;
         oe_nxt = 1'b0;
      end else begin
         case (state_r)
            amp_regs_pkg::BUS_ADDR, amp_regs_pkg::BUS_REG, amp_regs_pkg::BUS_WDATA: begin
               if (rise) begin
                  sh_nxt = {sh_r[6:0], sda_i};
                  cnt_nxt = cnt_r + 4'h1;
               end else if (fall && cnt_r == 4'h8) begin
                  cnt_nxt = 4'h0;
                  oe_nxt = 1'b1;
                  if (state_r == amp_regs_pkg::BUS_ADDR) begin
                     rw_nxt = sh_r[0];
                     oe_nxt = (sh_r[7:1] == DEV_ADDR);
                     state_nxt = oe_nxt ? amp_regs_pkg::BUS_ACK_ADDR
                                        : amp_regs_pkg::BUS_IDLE;
                  end else if (state_r == amp_regs_pkg::BUS_REG) begin
                     ptr_nxt = sh_r;
                     state_nxt = amp_regs_pkg::BUS_ACK_REG;
                  end else begin
                     wd_nxt = sh_r;
                     wr_nxt = 1'b1;
                     state_nxt = amp_regs_pkg::BUS_ACK_WDATA;
                  end
               end
            end
            amp_regs_pkg::BUS_ACK_ADDR: begin
               if (fall) begin
                  if (rw_r) begin
                     sh_nxt = rd_data_i;
                     oe_nxt = !rd_data_i[7];
                     state_nxt = amp_regs_pkg::BUS_RDATA;
                  end else begin
                     oe_nxt = 1'b0;
                     state_nxt = amp_regs_pkg::BUS_REG;
                  end
               end
            end
            amp_regs_pkg::BUS_ACK_REG, amp_regs_pkg::BUS_ACK_WDATA: begin
               if (fall) begin
                  oe_nxt = 1'b0;
                  if (state_r == amp_regs_pkg::BUS_ACK_WDATA) begin
                     ptr_nxt = ptr_r + 8'h01;
                  end
                  state_nxt = amp_regs_pkg::BUS_WDATA;
               end
            end
            amp_regs_pkg::BUS_RDATA: begin
               if (fall) begin
                  cnt_nxt = cnt_r + 4'h1;
                  sh_nxt = {sh_r[6:0], 1'b0};
                  oe_nxt = (cnt_r == 4'h7) ? 1'b0 : !sh_r[6];
                  if (cnt_r == 4'h7) begin
                     cnt_nxt = 4'h0;
                     ptr_nxt = ptr_r + 8'h01;
                     state_nxt = amp_regs_pkg::BUS_ACK_RDATA;
                  end
               end
            end
            amp_regs_pkg::BUS_ACK_RDATA: begin
               // A not-acknowledge from the host ends the read burst
               if (rise && sda_i) begin
                  state_nxt = amp_regs_pkg::BUS_IDLE;
               end else if (fall) begin
                  sh_nxt = rd_data_i;
                  oe_nxt = !rd_data_i[7];
                  state_nxt = amp_regs_pkg::BUS_RDATA;
               end
            end
            default: begin
               oe_nxt = 1'b0;
            end
         endcase
      end
   end

   // Registers
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= amp_regs_pkg::BUS_IDLE;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         ptr_r <= 8'h00;
         wd_r <= 8'h00;
         oe_r <= 1'b0;
         rw_r <= 1'b0;
         wr_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         scl_d_r <= scl_i;
         sda_d_r <= sda_i;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         ptr_r <= ptr_nxt;
         wd_r <= wd_nxt;
         oe_r <= oe_nxt;
         rw_r <= rw_nxt;
         wr_r <= wr_nxt;
      end
   end

   assign sda_oe_o = oe_r;
   assign wr_stb_o = wr_r;
   assign ptr_o = ptr_r;
   assign wr_data_o = wd_r;
endmodule

// ===== alert_pin_gate.sv
/*
 * Mask gating of fault and warning conditions onto the two open-drain alert
 * pins. Assumes condition inputs are already synchronous levels.
 */
`timescale 1ns/1ps
module alert_pin_gate (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Conditions and masks
   input wire logic [7:0] mask_i,
   input wire logic overcurrent_i,
   input wire logic thermal_shutdown_i,
   input wire logic undervoltage_i,
   input wire logic overvoltage_i,
   input wire logic dc_offset_i,
   input wire logic thermal_warning_i,
   input wire logic [3:0] clip_i,
   input wire logic clip_split_i,
   // Pin pull-down enables
   output logic fault_pin_oe_o,
   output logic warn_pin_oe_o
);
   logic fault_r, fault_nxt, warn_r, warn_nxt;
   logic clip_ok;

   // A set mask bit hides its category from the pin
   always_comb begin
      clip_ok = !mask_i[amp_regs_pkg::CLIP_MASK_BIT];
      fault_nxt = (overcurrent_i && !mask_i[amp_regs_pkg::OVERCURRENT_MASK_BIT])
         || (thermal_shutdown_i && !mask_i[amp_regs_pkg::THERMAL_SHUTDOWN_MASK_BIT])
         || (undervoltage_i && !mask_i[amp_regs_pkg::UNDERVOLTAGE_MASK_BIT])
         || (overvoltage_i && !mask_i[amp_regs_pkg::OVERVOLTAGE_MASK_BIT])
         || (dc_offset_i && !mask_i[amp_regs_pkg::DC_OFFSET_MASK_BIT])
         || (clip_ok && clip_split_i && |clip_i[3:2]);
      warn_nxt = (thermal_warning_i && !mask_i[amp_regs_pkg::THERMAL_WARNING_MASK_BIT])
         || (clip_ok && |clip_i[1:0])
         || (clip_ok && !clip_split_i && |clip_i[3:2]);
   end

   // Registered so the pins never glitch on mask writes
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fault_r <= 1'b0;
         warn_r <= 1'b0;
      end else begin
         fault_r <= fault_nxt;
         warn_r <= warn_nxt;
      end
   end

   assign fault_pin_oe_o = fault_r;
   assign warn_pin_oe_o = warn_r;
endmodule

// ===== amp_fault_mask_acdiag_regs.sv
/*
 * Thermal status, warning, alert pin mask and AC load diagnostic control
 * registers of a four-channel amplifier, reached over the two-wire control bus.
 * Assumes sensing logic supplies synchronous condition levels and that fault
 * clear and automatic-recovery controls come from neighbouring registers.
 */
`timescale 1ns/1ps
module amp_fault_mask_acdiag_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h6a // Arbitrary default
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Control bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Sensed conditions
   input wire logic overtemp_shutdown_flag_global_i,
   input wire logic [3:0] overtemp_shutdown_flag_ch_i,
   input wire logic otw_global_i,
   input wire logic [3:0] otw_ch_i,
   input wire logic overcurrent_i,
   input wire logic undervoltage_i,
   input wire logic overvoltage_i,
   input wire logic dc_offset_i,
   input wire logic [3:0] clip_i,
   // Controls from neighbouring registers
   input wire logic clear_fault_i,
   input wire logic overtemp_shutdown_flag_auto_recover_i,
   input wire logic clip_split_i,
   input wire logic parallel_bridged_mode_i,
   // Alert pins, open drain, active low on the wire
   output logic fault_pin_o,
   output logic fault_pin_oe_o,
   output logic warn_pin_o,
   output logic warn_pin_oe_o,
   // AC diagnostic controls
   output logic [3:0] ac_diag_enable_o,
   output logic [3:0] ac_diag_gain4_o,
   output logic ac_diag_loopback_enable_o,
   output logic [6:0] ac_diag_measure_length_o,
   output logic [1:0] ac_diag_test_current_o
);
   logic wr_stb;
   logic [7:0] ptr, wr_data;
   logic [7:0] rd_data;
   logic bus_oe;
   logic [4:0] overtemp_shutdown_flag_r, overtemp_shutdown_flag_nxt;
   logic [4:0] otw_r, otw_nxt;
   logic por_r, por_nxt;
   logic [7:0] mask_r, mask_nxt, gain_en_r, gain_en_nxt, setup_r, setup_nxt;
   logic [3:0] en_r, en_nxt, gain_r, gain_nxt;
   logic loop_r, loop_nxt;
   logic [6:0] len_r, len_nxt;
   logic [1:0] cur_r, cur_nxt;
   logic fault_oe, warn_oe;

   // Register write decode shared by the three writable registers
   function automatic logic [7:0] wr_sel(input logic stb, input logic [7:0] p,
                                         input logic [7:0] ofs, input logic [7:0] d,
                                         input logic [7:0] cur);
      wr_sel = (stb && p == ofs) ? d : cur;
   endfunction

   ctrl_bus_target #(
      .DEV_ADDR(DEV_ADDR)
   ) u_bus (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_oe_o(bus_oe),
      .wr_stb_o(wr_stb),
      .ptr_o(ptr),
      .wr_data_o(wr_data),
      .rd_data_i(rd_data)
   );

   // Read mux; unmapped offsets read as zero
   always_comb begin
      case (ptr)
         amp_regs_pkg::THERMAL_SHUTDOWN_FLAGS_OFS: rd_data = {3'h0, overtemp_shutdown_flag_r};
         amp_regs_pkg::WARNING_FLAGS_OFS: rd_data = {2'h0, por_r, otw_r};
         amp_regs_pkg::FAULT_PIN_MASK_OFS: rd_data = mask_r;
         amp_regs_pkg::AC_DIAG_GAIN_ENABLE_OFS: rd_data = gain_en_r;
         amp_regs_pkg::AC_DIAG_SETUP_OFS: rd_data = setup_r;
         default: rd_data = 8'h00;
      endcase
   end

   // Status capture; a new event wins over a clear in the same cycle
   always_comb begin
      if (overtemp_shutdown_flag_auto_recover_i) begin
         overtemp_shutdown_flag_nxt = {overtemp_shutdown_flag_global_i, overtemp_shutdown_flag_ch_i};
      end else begin
         overtemp_shutdown_flag_nxt = {overtemp_shutdown_flag_global_i, overtemp_shutdown_flag_ch_i} | (overtemp_shutdown_flag_r & {5{!clear_fault_i}});
      end
      otw_nxt = {otw_global_i, otw_ch_i};
      por_nxt = por_r && !clear_fault_i;
   end

   // Writable registers; reserved bits are kept as written
   always_comb begin
      mask_nxt = wr_sel(wr_stb, ptr, amp_regs_pkg::FAULT_PIN_MASK_OFS, wr_data, mask_r);
      gain_en_nxt = wr_sel(wr_stb, ptr, amp_regs_pkg::AC_DIAG_GAIN_ENABLE_OFS, wr_data,
                           gain_en_r);
      setup_nxt = wr_sel(wr_stb, ptr, amp_regs_pkg::AC_DIAG_SETUP_OFS, wr_data, setup_r);
   end

   // AC diagnostic control decode, one cycle behind the register
   always_comb begin
      en_nxt = gain_en_r[3:0];
      if (parallel_bridged_mode_i) begin
         gain_nxt = {{2{gain_en_r[amp_regs_pkg::GAIN_PAIR12_BIT]}},
                     {2{gain_en_r[amp_regs_pkg::GAIN_PAIR34_BIT]}}};
      end else begin
         gain_nxt = gain_en_r[7:4];
      end
      loop_nxt = setup_r[amp_regs_pkg::LOOPBACK_BIT];
      len_nxt = setup_r[amp_regs_pkg::MEASURE_LENGTH_BIT] ?
                amp_regs_pkg::MEASURE_LONG_CYCLES : amp_regs_pkg::MEASURE_SHORT_CYCLES;
      // Reserved current codes pass through; the host must not use them
      cur_nxt = setup_r[amp_regs_pkg::TEST_CURRENT_LSB +: 2];
   end

   // All state registers
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         overtemp_shutdown_flag_r <= amp_regs_pkg::THERMAL_SHUTDOWN_FLAGS_RST[4:0];
         otw_r <= amp_regs_pkg::WARNING_FLAGS_RST[4:0];
         por_r <= amp_regs_pkg::WARNING_FLAGS_RST[amp_regs_pkg::POR_BIT];
         mask_r <= amp_regs_pkg::FAULT_PIN_MASK_RST;
         gain_en_r <= amp_regs_pkg::AC_DIAG_GAIN_ENABLE_RST;
         setup_r <= amp_regs_pkg::AC_DIAG_SETUP_RST;
         en_r <= 4'h0;
         gain_r <= 4'h0;
         loop_r <= 1'b0;
         len_r <= amp_regs_pkg::MEASURE_SHORT_CYCLES;
         cur_r <= 2'h0;
      end else begin
         overtemp_shutdown_flag_r <= overtemp_shutdown_flag_nxt;
         otw_r <= otw_nxt;
         por_r <= por_nxt;
         mask_r <= mask_nxt;
         gain_en_r <= gain_en_nxt;
         setup_r <= setup_nxt;
         en_r <= en_nxt;
         gain_r <= gain_nxt;
         loop_r <= loop_nxt;
         len_r <= len_nxt;
         cur_r <= cur_nxt;
      end
   end

   // Shutdown flags drive the pin from the latched view, not the live input
   alert_pin_gate u_gate (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .mask_i(mask_r),
      .overcurrent_i(overcurrent_i),
      .thermal_shutdown_i(|overtemp_shutdown_flag_r),
      .undervoltage_i(undervoltage_i),
      .overvoltage_i(overvoltage_i),
      .dc_offset_i(dc_offset_i),
      .thermal_warning_i(|otw_r),
      .clip_i(clip_i),
      .clip_split_i(clip_split_i),
      .fault_pin_oe_o(fault_oe),
      .warn_pin_oe_o(warn_oe)
   );

   // Open-drain pins only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe_o = bus_oe;
   assign fault_pin_o = 1'b0;
   assign fault_pin_oe_o = fault_oe;
   assign warn_pin_o = 1'b0;
   assign warn_pin_oe_o = warn_oe;
   assign ac_diag_enable_o = en_r;
   assign ac_diag_gain4_o = gain_r;
   assign ac_diag_loopback_enable_o = loop_r;
   assign ac_diag_measure_length_o = len_r;
   assign ac_diag_test_current_o = cur_r;

   // Checks
   global_overtemp_shutdown_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      overtemp_shutdown_flag_global_i |=> overtemp_shutdown_flag_r[4])
      else $error("global shutdown flag not set");
   channel_overtemp_shutdown_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      ##1 ((overtemp_shutdown_flag_r[3:0] & $past(overtemp_shutdown_flag_ch_i)) == $past(overtemp_shutdown_flag_ch_i)))
      else $error("channel shutdown flag missing");
   por_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      clear_fault_i |=> !por_r ##1 !por_r)
      else $error("power-on flag did not clear");
   otw_follow_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      ##1 (otw_r[4] == $past(otw_global_i)))
      else $error("global warning does not follow");
   otw_channel_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      ##1 (otw_r[3:0] == $past(otw_ch_i)))
      else $error("channel warning mismatch");
   oc_to_pin_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (overcurrent_i && !mask_r[7]) |=> fault_pin_oe_o)
      else $error("overcurrent not on fault pin");
   overtemp_shutdown_flag_to_pin_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (|overtemp_shutdown_flag_r && !mask_r[6]) |=> fault_pin_oe_o)
      else $error("shutdown not on fault pin");
   uv_to_pin_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (undervoltage_i && !mask_r[5]) |=> fault_pin_oe_o)
      else $error("undervoltage not on fault pin");
   dc_to_pin_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (dc_offset_i && !mask_r[3]) |=> fault_pin_oe_o)
      else $error("dc offset not on fault pin");
   clip_masked_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (mask_r == 8'hff) |=> (!fault_pin_oe_o && !warn_pin_oe_o))
      else $error("pin active with all masked");
   ac_gain_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (!parallel_bridged_mode_i && $stable(gain_en_r)) |=> (gain_r == $past(gain_en_r[7:4])))
      else $error("gain select mismatch");
   ac_enable_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (wr_stb && ptr == amp_regs_pkg::AC_DIAG_GAIN_ENABLE_OFS) |=> ##1
      (en_r == $past(wr_data[3:0], 2)))
      else $error("enable not applied");
   loopback_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      ##1 (loop_r == $past(setup_r[7])))
      else $error("loopback mismatch");
   measure_len_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      setup_r[4] |=> (len_r == 7'h40))
      else $error("measure length wrong");
   latch_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
      (overtemp_shutdown_flag_r[4] && !overtemp_shutdown_flag_auto_recover_i && !clear_fault_i) |=> overtemp_shutdown_flag_r[4])
      else $error("latched shutdown lost");
endmodule

// ===== amp_host_model.sv
/*
 * Host model for the two-wire control bus: pointer writes and single reads.
 * Assumes the bench resolves an open-drain data wire with a pull-up.
 */
`timescale 1ns/1ps
module amp_host_model #(
   parameter logic [6:0] DEV = 7'h6a // Arbitrary target address
) (
   // Clock and bus
   input wire logic core_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o,
   // Read result strobe
   output logic got_o,
   output logic [7:0] data_o
);
   int nacks = 0;
   logic [7:0] q;
   logic k;
   // Idle bus: both lines released high
   initial begin
      scl_o = 1;
      sda_o = 1;
      got_o = 0;
      data_o = 8'h00;
   end
   // Third of a bit, kept above the four-cycle minimum half period
   task automatic hold();
      repeat (5) @(negedge core_clk_i);
   endtask
   // Data only moves while the clock is low
   task automatic bitx(input logic b, output logic s);
      sda_o = b;
      hold();
      scl_o = 1;
      hold();
      s = sda_i;
      scl_o = 0;
      hold();
   endtask
   task automatic start();
      sda_o = 1;
      hold();
      scl_o = 1;
      hold();
      sda_o = 0;
      hold();
      scl_o = 0;
      hold();
   endtask
   task automatic stop();
      sda_o = 0;
      hold();
      scl_o = 1;
      hold();
      sda_o = 1;
      hold();
   endtask
   task automatic bytex(input logic [7:0] d, input logic m);
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(m, k);
   endtask
   // A missing acknowledge is counted for the bench
   task automatic sendb(input logic [7:0] d);
      bytex(d, 1'b1);
      if (k !== 1'b0) nacks++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start();
      sendb({DEV, 1'b0});
      sendb(a);
      sendb(d);
      stop();
   endtask
   // Pointer write, repeated start, one byte then a closing no-acknowledge
   task automatic rd(input logic [7:0] a);
      start();
      sendb({DEV, 1'b0});
      sendb(a);
      start();
      sendb({DEV, 1'b1});
      bytex(8'hff, 1'b1);
      data_o = q;
      got_o = 1;
      @(negedge core_clk_i);
      got_o = 0;
      stop();
   endtask
endmodule

// ===== amp_fault_mask_acdiag_regs_test.sv
/*
 * Self-checking bench for the thermal, warning, pin mask and AC diagnostic
 * registers. Assumes the host model and a pulled-up data wire.
 */
`timescale 1ns/1ps
module amp_fault_mask_acdiag_regs_test;
   logic core_clk_i = 0;
   logic rst_b_i = 0;
   logic scl, sda_h, sda_oe, got, ow, clr, auto, fo, wo, lb;
   logic [7:0] rdat, r, s;
   logic [4:0] fc;
   logic [3:0] och, wch, clip, en, g4;
   logic [6:0] len;
   logic [1:0] cur;
   logic [15:0] lfsr = 16'hd98c;
   logic [7:0] expq[$];
   int num_errors = 0;
   int n_tests = 0;
   // Released data wire floats high through the pull-up
   wire sda = sda_h & ~sda_oe;
   always #5 core_clk_i = ~core_clk_i;
   amp_fault_mask_acdiag_regs amp_fault_mask_acdiag_regs_inst (
      .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe_o(sda_oe), .overtemp_shutdown_flag_global_i(fc[3]), .overtemp_shutdown_flag_ch_i(och), .otw_global_i(ow),
      .otw_ch_i(wch), .overcurrent_i(fc[4]), .undervoltage_i(fc[2]), .overvoltage_i(fc[1]),
      .dc_offset_i(fc[0]), .clip_i(clip), .clear_fault_i(clr), .overtemp_shutdown_flag_auto_recover_i(auto),
      .clip_split_i(1'b0), .parallel_bridged_mode_i(1'b0), .fault_pin_o(),
      .fault_pin_oe_o(fo), .warn_pin_o(), .warn_pin_oe_o(wo), .ac_diag_enable_o(en),
      .ac_diag_gain4_o(g4), .ac_diag_loopback_enable_o(lb), .ac_diag_measure_length_o(len),
      .ac_diag_test_current_o(cur));
   amp_host_model amp_host_model_inst (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl),
      .sda_o(sda_h), .got_o(got), .data_o(rdat));
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      amp_host_model_inst.rd(a);
   endtask
   task automatic clear();
      clr = 1;
      @(negedge core_clk_i);
      clr = 0;
   endtask
   // Alert pins settle one cycle after a raw condition, two cycles after a mask write or a thermal flag change
   task automatic pin(input logic [7:0] m, input logic [1:0] e);
      amp_host_model_inst.wr(8'h14, m);
      repeat (3) @(negedge core_clk_i);
      check({6'h00, fo, wo}, {6'h00, e});
   endtask
   // Every read result answers the oldest noted expectation
   always @(posedge got) check(rdat, expq.pop_front());
   // Hang guard, well beyond the expected run
   initial begin
      #600us;
      num_errors++;
      report_and_stop();
   end
   initial begin
      {fc, och, wch, clip, ow, clr} = '0;
      auto = 1;
      repeat (6) @(negedge core_clk_i);
      rst_b_i = 1;
      @(negedge core_clk_i);
      rd(8'h12, 8'h00);
      rd(8'h13, 8'h20);
      for (int i = 0; i < 3; i++) rd(8'(8'h14 + i), 8'h00);
      rd(8'h3c, 8'h00);
      amp_host_model_inst.wr(8'h13, 8'hff);
      clear();
      rd(8'h13, 8'h00);
      $display("test reset done");
      repeat (4) begin
         r = rnd();
         s = rnd();
         {fc[3], och, ow, wch} = {r[4:0], s[4:0]};
         rd(8'h12, {3'h0, r[4:0]});
         rd(8'h13, {3'h0, s[4:0]});
      end
      // Latched shutdown survives the condition until cleared
      {fc, och, ow, wch} = '0;
      auto = 0;
      clear();
      fc[3] = 1;
      @(negedge core_clk_i);
      fc[3] = 0;
      rd(8'h12, 8'h10);
      clear();
      rd(8'h12, 8'h00);
      auto = 1;
      $display("test status done");
      repeat (6) begin
         r = rnd();
         s = rnd() & 8'hf7; // Host stays off reserved current codes
         amp_host_model_inst.wr(8'h15, r);
         amp_host_model_inst.wr(8'h16, s);
         rd(8'h15, r);
         rd(8'h16, s);
         check({g4, en}, r);
         check({lb, len}, {s[7], s[4] ? 7'h40 : 7'h20});
         check({6'h00, cur}, {6'h00, s[3:2]});
      end
      $display("test controls done");
      for (int i = 0; i < 5; i++) begin
         fc = 5'h01 << i;
         pin(8'hff ^ (8'h08 << i), 2'b10);
         pin(8'hff, 2'b00);
      end
      fc = '0;
      ow = 1;
      pin(8'hfe, 2'b01);
      ow = 0;
      clip = 4'h1;
      pin(8'hfd, 2'b01);
      pin(8'hff, 2'b00);
      check(amp_host_model_inst.nacks[7:0], 8'h00);
      $display("test pins done");
      report_and_stop();
   end
endmodule
